// [boot_cmd_pkg.sv]
// Codes, states and carriers shared by the boot command interpreter
package boot_cmd_pkg;
    // Command codes
    localparam logic [7:0] CMD_DEV_INQ = 8'h20;
    localparam logic [7:0] CMD_DEV_SEL = 8'h10;
    localparam logic [7:0] CMD_CLK_INQ = 8'h21;
    localparam logic [7:0] CMD_CLK_SEL = 8'h11;
    localparam logic [7:0] CMD_DIV_INQ = 8'h22;
    localparam logic [7:0] CMD_FRQ_INQ = 8'h23;
    localparam logic [7:0] CMD_BOOT_INQ = 8'h24;
    localparam logic [7:0] CMD_USER_INQ = 8'h25;
    localparam logic [7:0] CMD_ERB_INQ = 8'h26;
    localparam logic [7:0] CMD_UNIT_INQ = 8'h27;
    localparam logic [7:0] CMD_RATE_SEL = 8'h3f;
    localparam logic [7:0] CMD_ENTER_PE = 8'h40;
    localparam logic [7:0] CMD_PSEL_BOOT = 8'h42;
    localparam logic [7:0] CMD_PSEL_USER = 8'h43;
    localparam logic [7:0] CMD_ESEL = 8'h48;
    localparam logic [7:0] CMD_SUM_BOOT = 8'h4a;
    localparam logic [7:0] CMD_SUM_USER = 8'h4b;
    localparam logic [7:0] CMD_BLK_BOOT = 8'h4c;
    localparam logic [7:0] CMD_BLK_USER = 8'h4d;
    localparam logic [7:0] CMD_STATUS = 8'h4f;
    localparam logic [7:0] CMD_PROG128 = 8'h50;
    localparam logic [7:0] CMD_READ = 8'h52;
    localparam logic [7:0] CMD_BERASE = 8'h58;
    // Answer bytes
    localparam logic [7:0] RSP_ACK = 8'h06;
    localparam logic [7:0] RSP_CMD_ERR = 8'h80;
    localparam logic [7:0] RSP_ERR_BIT = 8'h80;
    localparam logic [7:0] ERR_CHECKSUM = 8'h11;
    localparam logic [7:0] ERR_ADDRESS = 8'h2a;
    // Programming frame layout
    localparam int PROG_UNIT = 128;
    localparam int ADDR_BYTES = 4;
    localparam logic [31:0] PROG_END_ADDR = 32'hffffffff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // Flash array region selected for programming
    typedef enum logic {REGION_BOOT, REGION_USER} region_t;
    // Protocol phase
    typedef enum logic [2:0] {PH_NONE, PH_DEV, PH_CLK, PH_PE_WAIT, PH_PROG} phase_t;
    // Interpreter sequence
    typedef enum logic [2:0] {S_CMD, S_OP, S_ADDR, S_DATA, S_SUM, S_PROG, S_TX} seq_t;
    // Request to the routine engine
    typedef struct packed {
        logic req;
        logic [7:0] cmd;
        region_t region;
    } op_req_t;
    // Answer from the routine engine
    typedef struct packed {
        logic done;
        logic fail;
        logic [7:0] code;
    } op_rsp_t;
endpackage

// [byte_skid2.sv]
// Two-entry buffer with valid and ready on both sides
module byte_skid2 #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    typedef struct packed {
        logic hv;
        logic [WIDTH-1:0] hd;
        logic tv;
        logic [WIDTH-1:0] td;
    } skid_t;
    skid_t s_q, s_d;

    // Head feeds the output, tail catches a word while the head stalls
    always_comb begin
        s_d = s_q;
        if (s_q.hv && out_ready) begin
            s_d.hv = s_q.tv;
            s_d.hd = s_q.td;
            s_d.tv = 1'b0;
        end
        if (in_valid && !s_q.tv) begin
            if (!s_d.hv) begin
                s_d.hv = 1'b1;
                s_d.hd = in_data;
            end else begin
                s_d.tv = 1'b1;
                s_d.td = in_data;
            end
        end
    end

    // Registered state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign in_ready = !s_q.tv; // Full only when both entries hold words
    assign out_valid = s_q.hv;
    assign out_data = s_q.hd;
endmodule

// [boot_cmd_core.sv]
// Boot-mode flash command interpreter with byte streams in and out
// How it works
// - Bad, misordered or unacceptable command answers 80h then the command byte.
// - Clock mode selection before device selection, or late inquiries, are errors.
// - Transition command after clock mode and rate selection; acceptance enters programming state.
// - Programming state accepts boot and user programming selection, and 128-byte writes after a selection.
// - Programming state accepts erase selection and block erase.
// - Programming state accepts memory read and both region sum checks.
// - Programming state accepts both blank checks and the status inquiry.
// - All-ones address ends programming; device waits for a new selection.
// - Boot programming selection answers ACK, or C2h then the routine error.
// - User programming selection answers ACK, or C3h then the routine error.
// - Each 128-byte write goes to the region chosen by the last selection.
// - 128-byte write answers ACK, or D0h with checksum, address or write code.
// - Transition erases user then boot region; ACK, or C0h with erase code.
module boot_cmd_core #(
    parameter int UNIT = boot_cmd_pkg::PROG_UNIT
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_VALID,
    output logic RX_READY,
    output logic [7:0] TX_DATA,
    output logic TX_VALID,
    input wire logic TX_READY,
    output boot_cmd_pkg::op_req_t OP,
    input wire boot_cmd_pkg::op_rsp_t OP_RSP,
    output logic [31:0] PROG_ADDR,
    output logic [7:0] PROG_BYTE,
    output logic PROG_WE,
    output boot_cmd_pkg::phase_t PHASE
);
    localparam int CW = $clog2(UNIT + 1);

    typedef struct packed {
        boot_cmd_pkg::seq_t seq;
        boot_cmd_pkg::phase_t ph;
        logic rate_ok;
        boot_cmd_pkg::region_t region;
        logic [7:0] cmd;
        logic [7:0] sum;
        logic [CW-1:0] cnt;
        logic [31:0] addr;
        logic [7:0] tx0;
        logic [7:0] tx1;
        logic tx_two;
        logic tx_second;
        logic rx_rdy;
        boot_cmd_pkg::op_req_t op;
        logic we;
        logic [7:0] wbyte;
    } core_t;
    core_t s_q, s_d;

    logic take;
    logic acc;
    logic push_ready;
    logic [7:0] push_data;
    logic push_valid;

    assign take = RX_VALID && s_q.rx_rdy;
    assign push_valid = (s_q.seq == boot_cmd_pkg::S_TX);
    assign push_data = s_q.tx_second ? s_q.tx1 : s_q.tx0;

    // Acceptance of the incoming command byte in the current phase
    always_comb begin
        acc = 1'b0;
        if (s_q.ph == boot_cmd_pkg::PH_PE_WAIT || s_q.ph == boot_cmd_pkg::PH_PROG) begin
            case (RX_DATA)
                boot_cmd_pkg::CMD_PSEL_BOOT, boot_cmd_pkg::CMD_PSEL_USER:
                    acc = 1'b1;
                boot_cmd_pkg::CMD_PROG128:
                    acc = (s_q.ph == boot_cmd_pkg::PH_PROG);
                boot_cmd_pkg::CMD_ESEL, boot_cmd_pkg::CMD_BERASE:
                    acc = 1'b1;
                boot_cmd_pkg::CMD_READ, boot_cmd_pkg::CMD_SUM_BOOT, boot_cmd_pkg::CMD_SUM_USER:
                    acc = 1'b1;
                boot_cmd_pkg::CMD_BLK_BOOT, boot_cmd_pkg::CMD_BLK_USER, boot_cmd_pkg::CMD_STATUS:
                    acc = 1'b1;
                default:
                    acc = 1'b0;
            endcase
        end else begin
            case (RX_DATA)
                boot_cmd_pkg::CMD_DEV_INQ, boot_cmd_pkg::CMD_DEV_SEL:
                    acc = 1'b1;
                boot_cmd_pkg::CMD_CLK_INQ, boot_cmd_pkg::CMD_CLK_SEL:
                    acc = (s_q.ph != boot_cmd_pkg::PH_NONE);
                boot_cmd_pkg::CMD_DIV_INQ, boot_cmd_pkg::CMD_FRQ_INQ,
                boot_cmd_pkg::CMD_BOOT_INQ, boot_cmd_pkg::CMD_USER_INQ,
                boot_cmd_pkg::CMD_ERB_INQ, boot_cmd_pkg::CMD_UNIT_INQ,
                boot_cmd_pkg::CMD_RATE_SEL:
                    acc = (s_q.ph == boot_cmd_pkg::PH_CLK);
                boot_cmd_pkg::CMD_ENTER_PE:
                    acc = (s_q.ph == boot_cmd_pkg::PH_CLK) && s_q.rate_ok;
                default:
                    acc = 1'b0;
            endcase
        end
    end

    // Sequence, phase and answer framing
    always_comb begin
        s_d = s_q;
        s_d.op.req = 1'b0;
        s_d.we = 1'b0;
        case (s_q.seq)
            boot_cmd_pkg::S_CMD: begin
                if (take) begin
                    s_d.cmd = RX_DATA;
                    s_d.sum = RX_DATA;
                    s_d.cnt = '0;
                    if (!acc) begin
                        s_d.tx0 = boot_cmd_pkg::RSP_CMD_ERR;
                        s_d.tx1 = RX_DATA;
                        s_d.tx_two = 1'b1;
                        s_d.tx_second = 1'b0;
                        s_d.seq = boot_cmd_pkg::S_TX;
                    end else if (RX_DATA == boot_cmd_pkg::CMD_PROG128) begin
                        s_d.seq = boot_cmd_pkg::S_ADDR;
                    end else begin
                        s_d.op.req = 1'b1;
                        s_d.op.cmd = RX_DATA;
                        s_d.seq = boot_cmd_pkg::S_OP;
                    end
                end
            end
            boot_cmd_pkg::S_ADDR: begin
                if (take) begin
                    s_d.addr = {s_q.addr[23:0], RX_DATA};
                    s_d.sum = s_q.sum + RX_DATA;
                    s_d.cnt = s_q.cnt + 1'b1;
                    if (s_q.cnt == CW'(boot_cmd_pkg::ADDR_BYTES - 1)) begin
                        s_d.cnt = '0;
                        if ({s_q.addr[23:0], RX_DATA} == boot_cmd_pkg::PROG_END_ADDR) begin
                            s_d.seq = boot_cmd_pkg::S_SUM;
                        end else begin
                            s_d.seq = boot_cmd_pkg::S_DATA;
                        end
                    end
                end
            end
            boot_cmd_pkg::S_DATA: begin
                if (take) begin
                    s_d.sum = s_q.sum + RX_DATA;
                    s_d.we = 1'b1;
                    s_d.wbyte = RX_DATA;
                    s_d.cnt = s_q.cnt + 1'b1;
                    if (s_q.cnt == CW'(UNIT - 1)) begin
                        s_d.seq = boot_cmd_pkg::S_SUM;
                    end
                end
            end
            boot_cmd_pkg::S_SUM: begin
                if (take) begin
                    s_d.tx0 = boot_cmd_pkg::CMD_PROG128 | boot_cmd_pkg::RSP_ERR_BIT;
                    s_d.tx_two = 1'b1;
                    s_d.tx_second = 1'b0;
                    s_d.seq = boot_cmd_pkg::S_TX;
                    if (s_q.sum + RX_DATA != boot_cmd_pkg::ZERO_BYTE) begin
                        s_d.tx1 = boot_cmd_pkg::ERR_CHECKSUM;
                    end else if (s_q.addr == boot_cmd_pkg::PROG_END_ADDR) begin
                        s_d.tx0 = boot_cmd_pkg::RSP_ACK;
                        s_d.tx_two = 1'b0;
                        s_d.ph = boot_cmd_pkg::PH_PE_WAIT;
                    end else if (s_q.addr[$clog2(UNIT)-1:0] != '0) begin
                        s_d.tx1 = boot_cmd_pkg::ERR_ADDRESS;
                    end else begin
                        s_d.op.req = 1'b1;
                        s_d.op.cmd = boot_cmd_pkg::CMD_PROG128;
                        s_d.op.region = s_q.region;
                        s_d.seq = boot_cmd_pkg::S_OP;
                    end
                end
            end
            boot_cmd_pkg::S_OP: begin
                if (OP_RSP.done) begin
                    s_d.tx_second = 1'b0;
                    s_d.seq = boot_cmd_pkg::S_TX;
                    if (OP_RSP.fail) begin
                        // Error byte is the command with its top bit set, then the code
                        s_d.tx0 = s_q.cmd | boot_cmd_pkg::RSP_ERR_BIT;
                        s_d.tx1 = OP_RSP.code;
                        s_d.tx_two = 1'b1;
                    end else begin
                        s_d.tx0 = boot_cmd_pkg::RSP_ACK;
                        s_d.tx_two = 1'b0;
                        case (s_q.cmd)
                            boot_cmd_pkg::CMD_DEV_SEL:
                                s_d.ph = boot_cmd_pkg::PH_DEV;
                            boot_cmd_pkg::CMD_CLK_SEL: begin
                                s_d.ph = boot_cmd_pkg::PH_CLK;
                                s_d.rate_ok = 1'b0;
                            end
                            boot_cmd_pkg::CMD_RATE_SEL:
                                s_d.rate_ok = 1'b1;
                            boot_cmd_pkg::CMD_ENTER_PE:
                                s_d.ph = boot_cmd_pkg::PH_PE_WAIT;
                            boot_cmd_pkg::CMD_PSEL_BOOT: begin
                                s_d.ph = boot_cmd_pkg::PH_PROG;
                                s_d.region = boot_cmd_pkg::REGION_BOOT;
                            end
                            boot_cmd_pkg::CMD_PSEL_USER: begin
                                s_d.ph = boot_cmd_pkg::PH_PROG;
                                s_d.region = boot_cmd_pkg::REGION_USER;
                            end
                            boot_cmd_pkg::CMD_ESEL:
                                s_d.ph = boot_cmd_pkg::PH_PE_WAIT;
                            default: begin
                            end
                        endcase
                    end
                end
            end
            boot_cmd_pkg::S_TX: begin
                if (push_ready) begin
                    if (s_q.tx_two && !s_q.tx_second) begin
                        s_d.tx_second = 1'b1;
                    end else begin
                        s_d.seq = boot_cmd_pkg::S_CMD;
                    end
                end
            end
            default:
                s_d.seq = boot_cmd_pkg::S_CMD;
        endcase
        // Bytes are taken only in frame-reading states, one more not in the last one
        s_d.rx_rdy = (s_d.seq == boot_cmd_pkg::S_CMD) || (s_d.seq == boot_cmd_pkg::S_ADDR) ||
                     (s_d.seq == boot_cmd_pkg::S_DATA) || (s_d.seq == boot_cmd_pkg::S_SUM);
        if (take && s_q.rx_rdy && s_d.seq != s_q.seq && s_d.seq != boot_cmd_pkg::S_ADDR &&
            s_d.seq != boot_cmd_pkg::S_DATA && s_d.seq != boot_cmd_pkg::S_SUM) begin
            s_d.rx_rdy = 1'b0;
        end
    end

    // Registered state
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Answer bytes leave through the two-entry buffer
    byte_skid2 #(.WIDTH(8)) u_tx (
        .clk(MCLK),
        .rst(RST),
        .in_valid(push_valid),
        .in_data(push_data),
        .in_ready(push_ready),
        .out_valid(TX_VALID),
        .out_data(TX_DATA),
        .out_ready(TX_READY)
    );

    assign RX_READY = s_q.rx_rdy;
    assign OP = s_q.op;
    assign PROG_ADDR = s_q.addr;
    assign PROG_BYTE = s_q.wbyte;
    assign PROG_WE = s_q.we;
    assign PHASE = s_q.ph;
endmodule

// [boot_cmd_core_assertions.sv]
// Protocol checker for the boot command interpreter ports
module boot_cmd_core_assertions #(
    parameter int UNIT = 128
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_VALID,
    input wire logic RX_READY,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire boot_cmd_pkg::op_req_t OP,
    input wire boot_cmd_pkg::op_rsp_t OP_RSP,
    input wire logic [31:0] PROG_ADDR,
    input wire logic [7:0] PROG_BYTE,
    input wire logic PROG_WE,
    input wire boot_cmd_pkg::phase_t PHASE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    // Answer bytes expected after an engine reply
    sequence s_echo_err;
        ##[1:4] (TX_VALID && TX_DATA == (OP.cmd | 8'h80));
    endsequence
    sequence s_ack;
        ##[1:4] (TX_VALID && TX_DATA == 8'h06);
    endsequence
    // Answer bytes wait while the receiver stalls
    a_tx_hold: assert property (
        TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
        else $error("answer byte changed while stalled");
    a_cmd_err_pair: assert property (
        TX_VALID && TX_READY && TX_DATA == 8'h80 |=> ##[0:3] TX_VALID)
        else $error("command error lacks its second byte");
    a_req_cause: assert property (
        OP.req && OP.cmd != 8'h50 |-> !RX_READY && $past(RX_VALID && RX_READY))
        else $error("engine request without a received command");
    a_pe_entry: assert property (
        PHASE == boot_cmd_pkg::PH_PE_WAIT && $past(PHASE) == boot_cmd_pkg::PH_CLK
        |-> $past(OP.cmd) == 8'h40)
        else $error("programming state entered without transition");
    a_prog_entry: assert property (
        PHASE == boot_cmd_pkg::PH_PROG && $past(PHASE) != boot_cmd_pkg::PH_PROG
        |-> OP.cmd inside {8'h42, 8'h43})
        else $error("programming phase without a selection");
    a_we_phase: assert property (
        PROG_WE |-> PHASE == boot_cmd_pkg::PH_PROG)
        else $error("flash write outside programming phase");
    a_fail_echo: assert property (
        OP_RSP.done && OP_RSP.fail |-> s_echo_err)
        else $error("failure answer byte wrong or late");
    a_ack_after: assert property (
        OP_RSP.done && !OP_RSP.fail |-> s_ack)
        else $error("acknowledge missing after success");
endmodule

// [op_engine_model.sv]
// Routine engine model answering the interpreter's requests
module op_engine_model (
    input wire logic clk,
    input wire logic rst,
    input wire boot_cmd_pkg::op_req_t op,
    output boot_cmd_pkg::op_rsp_t rsp,
    input wire logic [7:0] lat,
    input wire logic fail_en,
    input wire logic [7:0] fail_code
);
    timeunit 1ns;
    timeprecision 1ps;
    // One request at a time, answered after a chosen delay; idle answer cleared on every edge
    always @(posedge clk) begin
        rsp <= '0;
        if (op.req && !rst) begin
            repeat (lat) @(posedge clk);
            rsp <= '{done: 1'b1, fail: fail_en, code: fail_code};
        end
    end
endmodule

// [tb.sv]
// Self-checking bench for the boot command interpreter
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int UNIT = 4;
    localparam logic [7:0] INQ [6] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27};
    localparam logic [7:0] PEQ [8] = '{8'h48, 8'h58, 8'h52, 8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h4f};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] rx_data = 8'h00;
    logic rx_valid = 1'b0;
    logic tx_ready = 1'b1;
    logic rx_ready, tx_valid, prog_we;
    logic [7:0] tx_data, prog_byte;
    logic [31:0] prog_addr;
    boot_cmd_pkg::op_req_t op;
    boot_cmd_pkg::op_rsp_t rsp;
    boot_cmd_pkg::phase_t phase;
    logic [7:0] lat = 8'h01;
    logic fail_en = 1'b0;
    logic [7:0] fail_code = 8'h00;
    int errors = 0;
    int tests_run = 0;
    logic [7:0] we_q[$];

    always #25 mclk = ~mclk;

    boot_cmd_core #(.UNIT(UNIT)) i_boot_cmd_core (.MCLK(mclk), .RST(rst), .RX_DATA(rx_data),
        .RX_VALID(rx_valid), .RX_READY(rx_ready), .TX_DATA(tx_data), .TX_VALID(tx_valid),
        .TX_READY(tx_ready), .OP(op), .OP_RSP(rsp), .PROG_ADDR(prog_addr),
        .PROG_BYTE(prog_byte), .PROG_WE(prog_we), .PHASE(phase));
    op_engine_model i_op_engine_model (.clk(mclk), .rst(rst), .op(op), .rsp(rsp), .lat(lat),
        .fail_en(fail_en), .fail_code(fail_code));

    // Collect bytes handed to the flash write path
    always @(posedge mclk) if (prog_we) we_q.push_back(prog_byte);

    task automatic end_of_test();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic hang(input string nm);
        errors++;
        $display("ERROR %s expected handshake seen none", nm);
        end_of_test();
    endtask

    // Offer a byte and hold it until taken
    task automatic send(input logic [7:0] b);
        int i;
        rx_data <= b;
        rx_valid <= 1'b1;
        for (i = 0; i < 400; i++) begin
            @(posedge mclk);
            if (rx_ready === 1'b1) break;
        end
        if (i == 400) hang("rx_ready");
    endtask

    // Take one answer byte and compare it
    task automatic get(input logic [7:0] e);
        int i;
        for (i = 0; i < 400; i++) begin
            @(posedge mclk);
            if (tx_valid === 1'b1 && tx_ready === 1'b1) break;
        end
        if (i == 400) hang("tx_valid");
        chk("tx_data", e, tx_data);
    endtask

    // One-byte command with a single acknowledge or a two-byte error answer
    task automatic cmd(input logic [7:0] c, input logic [7:0] e1, input logic [7:0] e2);
        send(c);
        rx_valid <= 1'b0;
        get(e1);
        if (e1 != 8'h06) get(e2);
    endtask

    // Programming frame; the end address carries no data bytes
    task automatic frame(input logic [31:0] a, input bit bad, input logic [7:0] e1,
        input logic [7:0] e2);
        logic [7:0] s;
        s = 8'h50 + a[31:24] + a[23:16] + a[15:8] + a[7:0];
        we_q.delete();
        send(8'h50);
        for (int k = 3; k >= 0; k--) send(a[k*8 +: 8]);
        if (a != 32'hffffffff) begin
            for (int k = 0; k < UNIT; k++) begin
                send(a[7:0] + 8'(k));
                s = s + a[7:0] + 8'(k);
            end
        end
        send(8'h00 - s + {7'h00, bad});
        rx_valid <= 1'b0;
        get(e1);
        if (e1 != 8'h06) get(e2);
    endtask

    // Commands refused before any device is chosen
    task automatic t_early();
        cmd(8'h11, 8'h80, 8'h11);
        cmd(8'h99, 8'h80, 8'h99);
        cmd(8'h40, 8'h80, 8'h40);
        chk("phase", boot_cmd_pkg::PH_NONE, phase);
    endtask

    // Both answer bytes wait in the buffer while the receiver stalls
    task automatic t_stall();
        tx_ready <= 1'b0;
        send(8'h99);
        rx_valid <= 1'b0;
        repeat (8) @(posedge mclk);
        chk("tx_data", 8'h80, tx_data);
        tx_ready <= 1'b1;
        get(8'h80);
        get(8'h99);
    endtask

    // Inquiry and selection order up to the programming state
    task automatic t_order();
        cmd(8'h20, 8'h06, 8'h00);
        cmd(8'h10, 8'h06, 8'h00);
        chk("phase", boot_cmd_pkg::PH_DEV, phase);
        cmd(8'h22, 8'h80, 8'h22);
        lat <= 8'h06;
        cmd(8'h21, 8'h06, 8'h00);
        cmd(8'h11, 8'h06, 8'h00);
        chk("phase", boot_cmd_pkg::PH_CLK, phase);
        cmd(8'h40, 8'h80, 8'h40);
        foreach (INQ[k]) cmd(INQ[k], 8'h06, 8'h00);
        cmd(8'h3f, 8'h06, 8'h00);
        fail_en <= 1'b1;
        fail_code <= 8'h51;
        cmd(8'h40, 8'hc0, 8'h51);
        fail_en <= 1'b0;
        cmd(8'h40, 8'h06, 8'h00);
        chk("phase", boot_cmd_pkg::PH_PE_WAIT, phase);
    endtask

    // Programming-state command set, a refused inquiry and a refused write before selection
    task automatic t_pe();
        foreach (PEQ[k]) cmd(PEQ[k], 8'h06, 8'h00);
        cmd(8'h20, 8'h80, 8'h20);
        cmd(8'h50, 8'h80, 8'h50);
    endtask

    // Selection failures, then frames into each region
    task automatic t_prog();
        fail_en <= 1'b1;
        fail_code <= 8'h54;
        cmd(8'h42, 8'hc2, 8'h54);
        cmd(8'h43, 8'hc3, 8'h54);
        fail_en <= 1'b0;
        cmd(8'h43, 8'h06, 8'h00);
        frame(32'h10, 1'b0, 8'h06, 8'h00);
        chk("region", boot_cmd_pkg::REGION_USER, op.region);
        chk("we_count", UNIT, we_q.size());
        foreach (we_q[k]) chk("we_byte", 8'h10 + k, we_q[k]);
        chk("prog_addr", 32'h10, prog_addr);
        frame(32'h14, 1'b0, 8'h06, 8'h00);
        frame(32'h11, 1'b0, 8'hd0, 8'h2a);
        frame(32'h18, 1'b1, 8'hd0, 8'h11);
        fail_en <= 1'b1;
        fail_code <= 8'h53;
        frame(32'h1c, 1'b0, 8'hd0, 8'h53);
        fail_en <= 1'b0;
        frame(32'hffffffff, 1'b0, 8'h06, 8'h00);
        chk("phase", boot_cmd_pkg::PH_PE_WAIT, phase);
        cmd(8'h42, 8'h06, 8'h00);
        frame(32'h20, 1'b0, 8'h06, 8'h00);
        chk("region", boot_cmd_pkg::REGION_BOOT, op.region);
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        t_early();
        t_stall();
        t_order();
        t_pe();
        t_prog();
        end_of_test();
    end
endmodule

bind boot_cmd_core boot_cmd_core_assertions #(.UNIT(UNIT)) i_chk (.MCLK(MCLK), .RST(RST),
    .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY), .TX_DATA(TX_DATA),
    .TX_VALID(TX_VALID), .TX_READY(TX_READY), .OP(OP), .OP_RSP(OP_RSP),
    .PROG_ADDR(PROG_ADDR), .PROG_BYTE(PROG_BYTE), .PROG_WE(PROG_WE), .PHASE(PHASE));
